// File: dcs_counter.sv
`timescale 1ns/100ps
module dcs_counter (
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    // control
    dcs_xfer_if.cnt   xf
);
    logic [9:0] remaining_ff;
    logic       done_ff;

    assign xf.remaining = remaining_ff;
    assign xf.done      = done_ff;

    // no clock gate: a load works at any time, counting down only while the channel runs
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            remaining_ff <= 10'h000;
        end else if (xf.load) begin
            remaining_ff <= xf.count;
        end else if (xf.run && xf.step && remaining_ff != 10'h000) begin
            remaining_ff <= remaining_ff - 10'h001;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= xf.run && xf.step && !xf.load &&
                       remaining_ff == 10'h001;
        end
    end
endmodule

// File: dcs_pkg.sv
// Behaviour
// - start trigger one sets channel running, waiting
// - writing zero to trigger does nothing
// - end flag reads one while request pending
// - mask zero allows interrupt, one blocks
// - enable zero stops channel and clock
// - enable zero refuses setup register writes
// - enable one runs channel, accepts setup
// - progress bit reads one while transfer runs
// - progress set after enable enters trigger wait
package dcs_pkg;
    localparam logic [11:0] start_trigger_off = 12'h000;
    localparam logic [11:0] chan_status_off   = 12'h004;
    localparam logic [11:0] req_flags_off     = 12'h008;
    localparam logic [11:0] mask_flags_off    = 12'h00c;
    localparam logic [11:0] op_control_off    = 12'h010;
    localparam logic [11:0] setup_config_off  = 12'h014;
    localparam logic [11:0] setup_addr_off    = 12'h018;
    localparam logic [11:0] setup_count_off   = 12'h01c;
    localparam logic [11:0] irq_status_off    = 12'h020;
    localparam logic [11:0] irq_mask_off      = 12'h024;
    localparam int          num_serial_chan   = 4;
    localparam int          dma_end_flag_pos  = 3;
    localparam int          dma_end_mask_pos  = 3;
    localparam int          dma_enable_pos    = 7;
    localparam int          dma_progress_pos  = 0;
    localparam logic [7:0]  req_flags_rst     = 8'h00;
    localparam logic [7:0]  mask_flags_rst    = 8'hff;
    localparam logic [7:0]  op_control_rst    = 8'h00;
    localparam logic [7:0]  setup_config_rst  = 8'h00;
    localparam logic [15:0] setup_addr_rst    = 16'h0000;
    localparam logic [9:0]  setup_count_rst   = 10'h000;
    localparam logic [1:0]  irq_mask_rst      = 2'h3;
    localparam int          irq_bit_dma_end   = 0;
    localparam int          irq_bit_serial    = 1;
endpackage

// File: dcs_props.sv
`timescale 1ns/100ps
module dcs_props (
    // clock, reset and bus
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    // observed outputs
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [3:0]  chan_operating_out,
    input wire logic        dma_clk_en_out,
    input wire logic        irq_out
);
    logic wr;
    logic wr_ctl;
    logic wr_trg;
    assign wr     = psel_in & penable_in & pwrite_in;
    assign wr_ctl = wr && paddr_in == dcs_pkg::op_control_off;
    assign wr_trg = wr && paddr_in == dcs_pkg::start_trigger_off;
    // shadow of both mask paths; the line may only rise if one is open
    logic m_all_ff;
    logic m_end_ff;
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            m_all_ff <= 1'b1;
            m_end_ff <= 1'b1;
        end else begin
            if (wr && paddr_in == dcs_pkg::irq_mask_off) begin
                m_all_ff <= pwdata_in[1:0] == 2'h3;
            end
            if (wr && paddr_in == dcs_pkg::mask_flags_off) begin
                m_end_ff <= pwdata_in[dcs_pkg::dma_end_mask_pos];
            end
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////
    a_bus_answer_ok: assert property (pready_out && !pslverr_out)
        else $error("bus answer not ready or flagged error");
    a_clk_en_follow: assert property (wr_ctl |=>
        dma_clk_en_out == $past(pwdata_in[7]))
        else $error("channel clock enable does not follow write");
    a_clk_en_hold: assert property (!wr_ctl |=> $stable(dma_clk_en_out))
        else $error("channel clock enable moved without write");
    a_trig_sets_chan: assert property (wr_trg |=>
        (chan_operating_out & $past(pwdata_in[3:0])) == $past(pwdata_in[3:0]))
        else $error("start trigger did not set operating bit");
    a_trig_zero_noop: assert property (
        wr_trg && pwdata_in[3:0] == 4'h0 |=> $stable(chan_operating_out))
        else $error("zero trigger changed operating bits");
    a_chan_stays_set: assert property (
        1'b1 |=> (chan_operating_out & $past(chan_operating_out))
        == $past(chan_operating_out))
        else $error("operating bit cleared");
    a_irq_mask_block: assert property (m_all_ff && m_end_ff |=> !irq_out)
        else $error("interrupt raised while fully masked");
    a_read_upper_zero: assert property (prdata_out[31:16] == 16'h0000)
        else $error("read data upper half not zero");
endmodule
bind dcs_top dcs_props u_props (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .chan_operating_out(chan_operating_out),
    .dma_clk_en_out(dma_clk_en_out), .irq_out(irq_out)
);

// File: dcs_top.sv
`timescale 1ns/100ps
module dcs_top (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // dma start request from the serial side (async pin)
    input  wire logic        dma_req_in,
    // status and interrupt
    output logic [3:0]       chan_operating_out,
    output logic             dma_clk_en_out,
    output logic             irq_out
);
    ////////////////////////////////////////////////////////////////////
    logic       wr_en;
    logic       rd_en;
    logic [3:0] chan_status_ff;
    logic [7:0] req_flags_ff;
    logic [7:0] mask_flags_ff;
    logic       enable_ff;
    logic       progress_ff;
    logic [7:0] setup_config_ff;
    logic [15:0] setup_addr_ff;
    logic [9:0] setup_count_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_mask_ff;
    logic [31:0] prdata_ff;
    logic       req_s1_ff;
    logic       req_s2_ff;
    logic       req_s3_ff;
    logic       count_load_ff;
    logic       serial_event;
    logic       nxt_progress;
    logic       req_edge;
    logic       setup_ok;

    dcs_xfer_if xf ();

    dcs_counter u_counter (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .xf          (xf)
    );

    ////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, every access completes in one
    assign wr_en       = psel_in && penable_in && pwrite_in;
    assign rd_en       = psel_in && penable_in && !pwrite_in;
    assign pready_out  = 1'b1;
    assign pslverr_out = 1'b0;
    assign prdata_out  = prdata_ff;
    assign setup_ok    = enable_ff;

    ////////////////////////////////////////////////////////////////////
    // start request synchroniser and rising edge
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
        end else begin
            req_s1_ff <= dma_req_in;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
        end
    end
    assign req_edge = req_s2_ff && !req_s3_ff;

    ////////////////////////////////////////////////////////////////////
    // serial start triggers: a written one sets the bit, zero is ignored
    assign serial_event = wr_en && paddr_in == dcs_pkg::start_trigger_off &&
                          pwdata_in[0];
    generate
        for (genvar i = 0; i < dcs_pkg::num_serial_chan; i++) begin : g_ch
            always_ff @(posedge core_clk_in) begin
                if (rst_in) begin
                    chan_status_ff[i] <= 1'b0;
                end else if (wr_en &&
                             paddr_in == dcs_pkg::start_trigger_off &&
                             pwdata_in[i]) begin
                    chan_status_ff[i] <= 1'b1;
                end
            end
        end
    endgenerate
    assign chan_operating_out = chan_status_ff;

    ////////////////////////////////////////////////////////////////////
    // operation control: enable and progress
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            enable_ff <= dcs_pkg::op_control_rst[dcs_pkg::dma_enable_pos];
        end else if (wr_en && paddr_in == dcs_pkg::op_control_off) begin
            enable_ff <= pwdata_in[dcs_pkg::dma_enable_pos];
        end
    end

    always_comb begin
        nxt_progress = progress_ff;
        if (xf.done) begin
            nxt_progress = 1'b0;
        end
        // progress only takes when the same write also sets enable
        if (wr_en && paddr_in == dcs_pkg::op_control_off) begin
            nxt_progress = pwdata_in[dcs_pkg::dma_progress_pos] &&
                           pwdata_in[dcs_pkg::dma_enable_pos];
        end
        if (!enable_ff && !(wr_en && paddr_in == dcs_pkg::op_control_off)) begin
            nxt_progress = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            progress_ff <= dcs_pkg::op_control_rst[dcs_pkg::dma_progress_pos];
        end else begin
            progress_ff <= nxt_progress;
        end
    end

    assign dma_clk_en_out = enable_ff;
    assign xf.run   = enable_ff && progress_ff;
    assign xf.step  = req_edge;
    assign xf.load  = count_load_ff;
    assign xf.count = setup_count_ff;

    ////////////////////////////////////////////////////////////////////
    // setup registers, writable only while enabled
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            setup_config_ff <= dcs_pkg::setup_config_rst;
        end else if (wr_en && setup_ok &&
                     paddr_in == dcs_pkg::setup_config_off) begin
            setup_config_ff <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            setup_addr_ff <= dcs_pkg::setup_addr_rst;
        end else if (wr_en && setup_ok &&
                     paddr_in == dcs_pkg::setup_addr_off) begin
            setup_addr_ff <= pwdata_in[15:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            setup_count_ff <= dcs_pkg::setup_count_rst;
            count_load_ff  <= 1'b0;
        end else begin
            count_load_ff <= wr_en && setup_ok &&
                             paddr_in == dcs_pkg::setup_count_off;
            if (wr_en && setup_ok && paddr_in == dcs_pkg::setup_count_off) begin
                setup_count_ff <= pwdata_in[9:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request flag and mask registers; hardware set wins over clear
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            req_flags_ff <= dcs_pkg::req_flags_rst;
        end else begin
            if (wr_en && paddr_in == dcs_pkg::req_flags_off) begin
                req_flags_ff <= pwdata_in[7:0];
            end
            if (xf.done) begin
                req_flags_ff[dcs_pkg::dma_end_flag_pos] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            mask_flags_ff <= dcs_pkg::mask_flags_rst;
        end else if (wr_en && paddr_in == dcs_pkg::mask_flags_off) begin
            mask_flags_ff <= pwdata_in[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sticky event status, cleared by a read; a new event beats the clear
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            irq_status_ff <= 2'h0;
        end else begin
            if (rd_en && paddr_in == dcs_pkg::irq_status_off) begin
                irq_status_ff <= 2'h0;
            end
            if (xf.done) begin
                irq_status_ff[dcs_pkg::irq_bit_dma_end] <= 1'b1;
            end
            if (serial_event) begin
                irq_status_ff[dcs_pkg::irq_bit_serial] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            irq_mask_ff <= dcs_pkg::irq_mask_rst;
        end else if (wr_en && paddr_in == dcs_pkg::irq_mask_off) begin
            irq_mask_ff <= pwdata_in[1:0];
        end
    end

    // the documented flag and mask also gate the line, so either path works
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (|(irq_status_ff & ~irq_mask_ff)) ||
                       (req_flags_ff[dcs_pkg::dma_end_flag_pos] &&
                        !mask_flags_ff[dcs_pkg::dma_end_mask_pos]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, registered in the setup phase
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            unique case (paddr_in)
                dcs_pkg::chan_status_off:
                    prdata_ff <= {28'h0, chan_status_ff};
                dcs_pkg::req_flags_off:
                    prdata_ff <= {24'h0, req_flags_ff};
                dcs_pkg::mask_flags_off:
                    prdata_ff <= {24'h0, mask_flags_ff};
                dcs_pkg::op_control_off:
                    prdata_ff <= {24'h0, enable_ff, 6'h00, progress_ff};
                dcs_pkg::setup_config_off:
                    prdata_ff <= {24'h0, setup_config_ff};
                dcs_pkg::setup_addr_off:
                    prdata_ff <= {16'h0, setup_addr_ff};
                dcs_pkg::setup_count_off:
                    prdata_ff <= {22'h0, xf.remaining};
                dcs_pkg::irq_status_off:
                    prdata_ff <= {30'h0, irq_status_ff};
                dcs_pkg::irq_mask_off:
                    prdata_ff <= {30'h0, irq_mask_ff};
                default:
                    prdata_ff <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// File: dcs_xfer_if.sv
`timescale 1ns/100ps
interface dcs_xfer_if;
    logic       run;
    logic       load;
    logic [9:0] count;
    logic       step;
    logic       done;
    logic [9:0] remaining;
    modport ctrl (output run, output load, output count, output step,
                  input done, input remaining);
    modport cnt  (input run, input load, input count, input step,
                  output done, output remaining);
endinterface

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        core_clk_in;
    logic        rst_in;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        dma_req_in;
    logic [3:0]  chan_operating_out;
    logic        dma_clk_en_out;
    logic        irq_out;
    logic [31:0] exp_q[$];
    logic [31:0] n;
    logic [31:0] a;
    int          bad_count;
    int          checked;
    int          cyc;
    dcs_top dut (
        .core_clk_in        (core_clk_in),
        .rst_in             (rst_in),
        .psel_in            (psel_in),
        .penable_in         (penable_in),
        .pwrite_in          (pwrite_in),
        .paddr_in           (paddr_in),
        .pwdata_in          (pwdata_in),
        .prdata_out         (prdata_out),
        .pready_out         (pready_out),
        .pslverr_out        (pslverr_out),
        .dma_req_in         (dma_req_in),
        .chan_operating_out (chan_operating_out),
        .dma_clk_en_out     (dma_clk_en_out),
        .irq_out            (irq_out)
    );
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_pin(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected pin at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // an idle cycle after each transfer keeps psel from two writes at once
    task automatic xfer(input logic w, input logic [11:0] ad,
                        input logic [31:0] d);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= ad;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        @(posedge core_clk_in);
        while (pready_out !== 1'b1) @(posedge core_clk_in);
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge core_clk_in);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, ad, 32'h0);
    endtask
    // pins are sampled mid-cycle, after the edge's updates have landed
    task automatic pin(input int s, input logic [31:0] e);
        @(negedge core_clk_in);
        cmp_pin(s == 0 ? {28'h0, chan_operating_out} :
            s == 1 ? {31'h0, dma_clk_en_out} : {31'h0, irq_out}, e);
        @(posedge core_clk_in);
    endtask
    task automatic pulse(input logic [31:0] k);
        repeat (k) begin
            dma_req_in <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            dma_req_in <= 1'b0;
            repeat (4) @(posedge core_clk_in);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(posedge core_clk_in) begin
        if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1) begin
            cmp(prdata_out, exp_q.pop_front());
        end
    end
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        rst_in     = 1'b1;
        psel_in    = 1'b0;
        penable_in = 1'b0;
        pwrite_in  = 1'b0;
        paddr_in   = 12'h000;
        pwdata_in  = 32'h0;
        dma_req_in = 1'b0;
        void'($urandom(67));
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        rd(dcs_pkg::req_flags_off, 32'h0);
        rd(dcs_pkg::mask_flags_off, 32'hff);
        rd(dcs_pkg::op_control_off, 32'h0);
        rd(dcs_pkg::irq_mask_off, 32'h3);
        rd(12'h030, 32'h0);
        pin(1, 32'h0);
        $display("reset test done");
        xfer(1'b1, dcs_pkg::start_trigger_off, 32'h0);
        pin(0, 32'h0);
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, dcs_pkg::start_trigger_off, 32'h1 << k);
            pin(0, (32'h2 << k) - 32'h1);
        end
        rd(dcs_pkg::chan_status_off, 32'hf);
        rd(dcs_pkg::irq_status_off, 32'h2);
        rd(dcs_pkg::irq_status_off, 32'h0);
        $display("trigger test done");
        n = 32'h2 + $urandom_range(2, 0);
        a = $urandom & 32'hffff;
        xfer(1'b1, dcs_pkg::setup_addr_off, a);
        xfer(1'b1, dcs_pkg::setup_count_off, n);
        xfer(1'b1, dcs_pkg::setup_config_off, a);
        rd(dcs_pkg::setup_config_off, 32'h0);
        rd(dcs_pkg::setup_addr_off, 32'h0);
        rd(dcs_pkg::setup_count_off, 32'h0);
        xfer(1'b1, dcs_pkg::op_control_off, 32'h80);
        pin(1, 32'h1);
        xfer(1'b1, dcs_pkg::setup_addr_off, a);
        rd(dcs_pkg::setup_addr_off, a);
        xfer(1'b1, dcs_pkg::setup_config_off, a);
        rd(dcs_pkg::setup_config_off, a & 32'hff);
        xfer(1'b1, dcs_pkg::setup_count_off, n);
        xfer(1'b1, dcs_pkg::req_flags_off, 32'h0);
        xfer(1'b1, dcs_pkg::mask_flags_off, 32'hf7);
        rd(dcs_pkg::mask_flags_off, 32'hf7);
        xfer(1'b1, dcs_pkg::irq_mask_off, 32'h0);
        xfer(1'b1, dcs_pkg::op_control_off, 32'h81);
        rd(dcs_pkg::op_control_off, 32'h81);
        pulse(n - 32'h1);
        rd(dcs_pkg::setup_count_off, 32'h1);
        rd(dcs_pkg::op_control_off, 32'h81);
        pin(2, 32'h0);
        pulse(32'h1);
        rd(dcs_pkg::op_control_off, 32'h80);
        rd(dcs_pkg::req_flags_off, 32'h8);
        pin(2, 32'h1);
        rd(dcs_pkg::irq_status_off, 32'h1);
        // the end flag also drives the line until software clears it
        xfer(1'b1, dcs_pkg::req_flags_off, 32'h0);
        pin(2, 32'h0);
        $display("transfer test done");
        xfer(1'b1, dcs_pkg::mask_flags_off, 32'hff);
        xfer(1'b1, dcs_pkg::irq_mask_off, 32'h3);
        xfer(1'b1, dcs_pkg::setup_count_off, 32'h1);
        xfer(1'b1, dcs_pkg::op_control_off, 32'h81);
        pulse(32'h1);
        pin(2, 32'h0);
        rd(dcs_pkg::irq_status_off, 32'h1);
        // a live count of one proves the stopped channel does not step
        xfer(1'b1, dcs_pkg::setup_count_off, 32'h1);
        xfer(1'b1, dcs_pkg::op_control_off, 32'h0);
        pin(1, 32'h0);
        xfer(1'b1, dcs_pkg::op_control_off, 32'h1);
        rd(dcs_pkg::op_control_off, 32'h0);
        pulse(32'h1);
        rd(dcs_pkg::irq_status_off, 32'h0);
        rd(dcs_pkg::setup_count_off, 32'h1);
        $display("mask and disable test done");
        end_of_test();
    end
endmodule
